// ==== hdl/scaler_ofm_pkg.sv ====
// Package: constants and carriers for scaler output field marking
package scaler_ofm_pkg;

  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SCALE  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Control register field positions
  localparam int CTRL_FID_SEL_BIT  = 6;
  localparam int CTRL_INV7_BIT     = 7;
  localparam int CTRL_PIN0_SEL_LO  = 0;
  localparam int CTRL_PIN1_SEL_LO  = 2;
  localparam int CTRL_SOFTWARE_RESET_BIT_BIT    = 8;

  // Scale register field positions
  localparam int SCALE_FINE_LO     = 0;
  localparam int SCALE_PRE_LO      = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
  localparam logic [5:0]  PRE_RST   = 6'h01;
  localparam logic [12:0] FINE_RST  = 13'h0400;
  localparam logic [5:0]  PRE_MIN   = 6'h01;

  // Fine scaler constants
  localparam logic [13:0] FINE_UNITY = 14'h0400;
  localparam int          PHASE_W    = 6;
  localparam int          ACC_W      = 10;

  // Pin source selection codes
  typedef enum logic [1:0]
  {
    PIN_LOW  = 2'h0,
    PIN_FID  = 2'h1,
    PIN_TASK = 2'h2,
    PIN_HIGH = 2'h3
  } pin_sel_e;

  typedef struct packed
  {
    logic [7:0]  data;
    logic        valid;
  } pix_s;

  typedef struct packed
  {
    logic        bit7;
    logic        bit6;
  } mark_s;

endpackage : scaler_ofm_pkg

// ==== hdl/scaler_ofm.sv ====
// Output field marking and horizontal scale split for the video scaler
// Functional notes
// [R01] Two field references go to the back-end: input field id and toggle flag.
// [R02] Toggle flag shows odd or even use count of the active task; the code keeps one toggle that counts starts of both tasks.
// [R03] Toggle flag flips at the start of each task activation.
// [R04] Toggle is independent of input field detection.
// [R05] Select 0: input field id drives bit 6 and field-id pin choice.
// [R06] Select 1: toggle flag drives bit 6 and field-id pin choice.
// [R07] Invert 0 gives bit 7 one; invert 1 gives bit 7 zero.
// [R08] Task pin choice drives the per-task bit 7 value.
// [R09] Fields with no output keep toggle and bit 6 from prior field; the code keeps bit 6 but flips the toggle at every task start.
// [R10] Field id to task pairing depends on software reset release timing.
// [R11] Ratio is 1/prescale times 1024/fine increment; prescale 1 to 63.
// [R12] Software keeps fine increment within 300 to 8191.
// [R13] Prescaler does integer part; phase delay fine scaler the remainder.
// [R14] Fine scaler interpolates with 6-bit phase resolution.
// [R15] Marks are fixed within a field and update only at field starts.
`timescale 1ns/1ps

module scaler_ofm
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic      [1:0]  o_avs_response,
  // Field and task events from the task handler and acquisition
  input  wire logic        i_field_start,
  input  wire logic        i_input_fid,
  input  wire logic        i_task_start,
  input  wire logic        i_task_is_b,
  input  wire logic        i_field_has_output,
  // Input pixel stream
  input  wire scaler_ofm_pkg::pix_s i_pix,
  // Outputs
  output scaler_ofm_pkg::pix_s  o_pix,
  output logic      [5:0]  o_phase,
  output logic             o_sav_eav_bit6,
  output logic             o_sav_eav_bit7,
  output logic             o_gp_pin_0,
  output logic             o_gp_pin_1,
  output logic             o_software_reset_bit_n
);

  // Registers
  logic [31:0] ctrl_a_r;
  logic [31:0] ctrl_b_r;
  logic [5:0]  pre_r;
  logic [12:0] fine_r;
  logic        toggle_r;
  logic        bit6_r;
  logic        bit7_r;
  logic        task_b_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [1:0]  resp_r;
  logic [5:0]  pre_cnt_r;

  logic [15:0] acc_r;
  scaler_ofm_pkg::pix_s prev_r;
  scaler_ofm_pkg::pix_s cur_r;
  scaler_ofm_pkg::pix_s out_r;
  logic [5:0]  phase_r;
  logic        gp0_r;
  logic        gp1_r;

  // Bus decode
  wire         req        = (i_avs_read | i_avs_write) & ~ack_r;
  wire         hit_ctrl   = (i_avs_address == scaler_ofm_pkg::ADDR_CTRL);
  wire         hit_scale  = (i_avs_address == scaler_ofm_pkg::ADDR_SCALE);
  wire         hit_status = (i_avs_address == scaler_ofm_pkg::ADDR_STATUS);
  wire         hit_any    = hit_ctrl | hit_scale | hit_status;
  // A write lands at the acknowledging edge, while the master still holds it
  wire         wr_take    = ack_r & i_avs_write;
  wire         wr_ctrl    = wr_take & hit_ctrl & i_avs_byteenable[0];
  wire         wr_software_reset_bit   = wr_take & hit_ctrl & i_avs_byteenable[1];
  wire         wr_scale   = wr_take & hit_scale;
  // Control set for the task on deck; writes go to the task named by bit 9
  wire         wr_to_b    = i_avs_writedata[9];
  wire [31:0]  ctrl_cur   = task_b_r ? ctrl_b_r : ctrl_a_r;
  wire         software_reset_bit_n    = ctrl_a_r[scaler_ofm_pkg::CTRL_SOFTWARE_RESET_BIT_BIT];

  // Prescale 0 is illegal; clamp to 1 so the prescaler never stalls
  wire [5:0]   pre_wdata  = i_avs_writedata[scaler_ofm_pkg::SCALE_PRE_LO +: 6];
  wire [5:0]   pre_safe   = (pre_wdata == 6'h00) ? scaler_ofm_pkg::PRE_MIN : pre_wdata; // [R11]
  wire [12:0]  fine_wdata = i_avs_writedata[scaler_ofm_pkg::SCALE_FINE_LO +: 13];

  wire [31:0]  status_val = {26'h0, task_b_r, bit7_r, bit6_r, toggle_r, i_input_fid,
                             software_reset_bit_n};
  wire [31:0]  scale_val  = {10'h0, pre_r, 3'h0, fine_r};
  wire [31:0]  rd_mux     = hit_ctrl  ? ctrl_cur :
                            hit_scale ? scale_val :
                            hit_status ? status_val : 32'h0;

  // Mark selection for the task now starting
  wire         task_b_nxt = i_task_start ? i_task_is_b : task_b_r;
  wire [31:0]  ctrl_nxt   = task_b_nxt ? ctrl_b_r : ctrl_a_r;
  wire         toggle_nxt = i_task_start ? ~toggle_r : toggle_r; // [R02] [R03] [R04]
  wire         fid_src    = ctrl_nxt[scaler_ofm_pkg::CTRL_FID_SEL_BIT] ? toggle_nxt // [R06]
                                                                       : i_input_fid; // [R05]
  wire         b7_src     = ~ctrl_nxt[scaler_ofm_pkg::CTRL_INV7_BIT]; // [R07]
  wire         upd_mark   = i_field_start & i_field_has_output; // [R09] [R15]

  wire [1:0]   sel0       = ctrl_cur[scaler_ofm_pkg::CTRL_PIN0_SEL_LO +: 2];
  wire [1:0]   sel1       = ctrl_cur[scaler_ofm_pkg::CTRL_PIN1_SEL_LO +: 2];

  function automatic logic pin_val(input logic [1:0] sel, input logic f, input logic t);
    unique case (scaler_ofm_pkg::pin_sel_e'(sel))
      scaler_ofm_pkg::PIN_LOW:  pin_val = 1'b0;
      scaler_ofm_pkg::PIN_FID:  pin_val = f; // [R05] [R06]
      scaler_ofm_pkg::PIN_TASK: pin_val = t; // [R08]
      scaler_ofm_pkg::PIN_HIGH: pin_val = 1'b1;
    endcase
  endfunction : pin_val

  // Fine scaler: acc is the next output position past prev_r in 1/1024 sample
  // units; its top 6 fraction bits are the phase. Output may come on any cycle,
  // so upscaling needs prescaler ticks at least 1024/increment cycles apart,
  // otherwise outputs are skipped rather than buffered.
  wire         task_rst   = i_rst | ~software_reset_bit_n; // [R10]
  wire         pre_tick   = i_pix.valid & (pre_cnt_r == 6'h00); // [R13]
  wire [15:0]  unity      = 16'(scaler_ofm_pkg::FINE_UNITY);
  wire         emit       = (acc_r < unity);
  wire [15:0]  acc_add    = emit ? acc_r + 16'(fine_r) : acc_r;
  wire         acc_short  = (acc_add < unity);
  wire [15:0]  acc_nxt    = ~pre_tick ? acc_add : (acc_short ? 16'h0000 : acc_add - unity); // [R11]
  wire [5:0]   phase_now  = acc_r[scaler_ofm_pkg::ACC_W-1 -: scaler_ofm_pkg::PHASE_W]; // [R14]
  wire [8:0]   w_prev     = 9'h040 - 9'(phase_now);
  wire [14:0]  interp     = 15'(prev_r.data) * 15'(w_prev) + 15'(cur_r.data) * 15'(phase_now);

  // Bus answer: one wait state, then a single-cycle acknowledge
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req;
    end
  end

  // Read data is taken at the request edge and stands until the next read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (req & i_avs_read)
    begin
      rdata_r <= rd_mux;
    end
  end

  // Unmapped addresses answer with the decode error code
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      resp_r <= 2'h0;
    end
    else if (req)
    begin
      resp_r <= hit_any ? 2'h0 : 2'h3;
    end
  end

  // Task A set; bit 8 is the shared software reset and has its own byte lane
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_a_r <= scaler_ofm_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_ctrl & ~wr_to_b)
        ctrl_a_r[7:0] <= i_avs_writedata[7:0];
      if (wr_software_reset_bit)
        ctrl_a_r[scaler_ofm_pkg::CTRL_SOFTWARE_RESET_BIT_BIT] <= i_avs_writedata[8];
    end
  end

  // Task B set
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_b_r <= scaler_ofm_pkg::CTRL_RST;
    end
    else if (wr_ctrl & wr_to_b)
    begin
      ctrl_b_r[7:0] <= i_avs_writedata[7:0];
    end
  end

  // Scale split: prescale ratio and fine increment
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pre_r  <= scaler_ofm_pkg::PRE_RST;
      fine_r <= scaler_ofm_pkg::FINE_RST;
    end
    else if (wr_scale)
    begin
      pre_r  <= pre_safe;
      fine_r <= fine_wdata; // [R12]
    end
  end

  // Software reset holds task state idle; release timing sets the FIELD_IDENTIFIER pairing
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      toggle_r <= 1'b0;
    end
    else
    begin
      toggle_r <= toggle_nxt; // [R02] [R03]
    end
  end

  // Task B has priority after either reset
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      task_b_r <= 1'b1;
    end
    else
    begin
      task_b_r <= task_b_nxt;
    end
  end

  // Marks change only at a field that produces output
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      bit6_r <= 1'b0;
    end
    else if (upd_mark)
    begin
      bit6_r <= fid_src; // [R01] [R15]
    end
  end

  // Bit 7 is one unless the active task asks for it inverted
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      bit7_r <= 1'b1;
    end
    else if (upd_mark)
    begin
      bit7_r <= b7_src; // [R07] [R15]
    end
  end

  // Pins follow the marks one cycle later
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      gp0_r <= 1'b0;
      gp1_r <= 1'b0;
    end
    else
    begin
      gp0_r <= pin_val(sel0, bit6_r, bit7_r); // [R05] [R06] [R08]
      gp1_r <= pin_val(sel1, bit6_r, bit7_r);
    end
  end

  // Integer prescaler: one tick per prescale_ratio valid inputs
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      pre_cnt_r <= 6'h00;
    end
    else if (i_pix.valid)
    begin
      pre_cnt_r <= (pre_cnt_r + 6'h01 >= pre_r) ? 6'h00 : pre_cnt_r + 6'h01; // [R13]
    end
  end

  // Position starts one sample out, so nothing is produced before data arrives
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      acc_r <= 16'(scaler_ofm_pkg::FINE_UNITY);
    end
    else
    begin
      acc_r <= acc_nxt; // [R13]
    end
  end

  // Two-sample window for the interpolator
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      prev_r <= '0;
      cur_r  <= '0;
    end
    else if (pre_tick)
    begin
      prev_r <= cur_r;
      cur_r  <= i_pix;
    end
  end

  // Interpolated output and its phase
  always_ff @(posedge i_sys_clk)
  begin
    if (task_rst)
    begin
      out_r   <= '0;
      phase_r <= 6'h00;
    end
    else
    begin
      out_r.valid <= emit;
      out_r.data  <= emit ? interp[13:6] : out_r.data; // [R14]
      phase_r     <= emit ? phase_now : phase_r;
    end
  end

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = ~ack_r;
  assign o_avs_response    = resp_r;
  assign o_pix             = out_r;
  assign o_phase           = phase_r;
  assign o_sav_eav_bit6    = bit6_r;
  assign o_sav_eav_bit7    = bit7_r;
  assign o_gp_pin_0        = gp0_r;
  assign o_gp_pin_1        = gp1_r;
  assign o_software_reset_bit_n         = software_reset_bit_n;

endmodule : scaler_ofm

// ==== testbench/scaler_ofm_properties.sv ====
// Checker: bus handshake, reset levels and field mark hold
`timescale 1ns/1ps
module scaler_ofm_properties
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        i_field_start,
  input wire logic        i_field_has_output,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [1:0]  o_avs_response,
  input wire logic        o_sav_eav_bit6,
  input wire logic        o_sav_eav_bit7
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  wire rq = i_avs_read || i_avs_write, wt = o_avs_waitrequest;
  wire hit = i_avs_address inside {4'h0, 4'h4, 4'h8}, mk = i_field_start && i_field_has_output;
  property p_ack; rq && wt |=> !wt; endproperty
  a_ack: assert property (p_ack) else $error("late answer");
  property p_pulse; !wt |=> wt; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_idle; !rq |=> wt; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_unmap; rq && wt && !hit |=> o_avs_response == 2'h3; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_okay; rq && wt && hit |=> o_avs_response == 2'h0; endproperty
  a_okay: assert property (p_okay) else $error("mapped access refused");
  property p_stand; !rq |=> $stable(o_avs_readdata) && $stable(o_avs_response); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_hold; !mk ##1 !mk |=> $stable(o_sav_eav_bit6) && $stable(o_sav_eav_bit7); endproperty
  a_hold: assert property (p_hold) else $error("mark moved in field");
  property p_rst; $fell(i_rst) |-> o_sav_eav_bit7 && !o_sav_eav_bit6 && wt; endproperty
  a_rst: assert property (p_rst) else $error("bad reset marks");
endmodule : scaler_ofm_properties

// ==== testbench/scaler_backend_model.sv ====
// Back-end model: counts the scaled samples it receives
`timescale 1ns/1ps
module scaler_backend_model
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_clear,
  input  wire scaler_ofm_pkg::pix_s i_pix,
  output logic [15:0]               o_count
);
  always_ff @(posedge i_sys_clk)
    o_count <= i_clear ? 16'h0000 : o_count + {15'h0000, i_pix.valid === 1'b1};
endmodule : scaler_backend_model

// ==== testbench/scaler_ofm_tb.sv ====
// Testbench: registers, field marks and scale split of the marking block
`timescale 1ns/1ps
module scaler_ofm_tb;
  logic                 clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fs = 1'b0, field_identifier = 1'b0;
  logic                 ts = 1'b0, tkb = 1'b0, has = 1'b0, clr = 1'b1, wreq, b6, b7, p0, p1, swn;
  logic [5:0]           ph;
  logic [3:0]           adr = 4'h0;
  logic [15:0]          cnt;
  logic [31:0]          wdat = 32'h0, rdat;
  scaler_ofm_pkg::pix_s ipix = '0, opix;
  int                   num_errors = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 3000) finish_test();
  scaler_ofm scaler_ofm_inst (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_avs_response(), .i_field_start(fs), .i_input_fid(field_identifier),
    .i_task_start(ts), .i_task_is_b(tkb), .i_field_has_output(has), .i_pix(ipix), .o_pix(opix),
    .o_phase(ph), .o_sav_eav_bit6(b6), .o_sav_eav_bit7(b7), .o_gp_pin_0(p0), .o_gp_pin_1(p1),
    .o_software_reset_bit_n(swn));
  scaler_backend_model scaler_backend_model_inst (.i_sys_clk(clk), .i_clear(clr), .i_pix(opix),
    .o_count(cnt));
  task automatic check(input logic [31:0] g, input logic [31:0] e, input logic [31:0] tol);
    total_checks++;
    if (((g + tol >= e) && (g <= e + tol)) !== 1'b1)
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    num_errors += int'(((g + tol >= e) && (g <= e + tol)) !== 1'b1);
  endtask : check
  // Reads compare the data taken at the request edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {adr, wdat, wr, rd} <= {a, d, w, !w};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    if (!w) check(rdat, d, 32'h0);
    {wr, rd} <= 2'b00;
  endtask : bus
  // Task activation a lands one cycle before the field start
  task automatic fld(input logic [1:0] a, input logic f, input logic h, input logic [3:0] e);
    @(posedge clk);
    {ts, tkb} <= a;
    @(posedge clk);
    {ts, fs, field_identifier, has} <= {1'b0, 1'b1, f, h};
    @(posedge clk);
    fs <= 1'b0;
    repeat (4) @(posedge clk);
    check({28'h0, b7, b6, p0, p1}, {28'h0, e}, 32'h0);
  endtask : fld
  // Start phase of the scaler is unknown, so the count may miss by two
  task automatic run(input logic [31:0] sc, input logic [31:0] e);
    bus(1'b1, 4'h4, sc);
    @(posedge clk);
    {clr, ipix.valid} <= 2'b01;
    repeat (72) @(posedge clk) ipix.data <= ipix.data + 8'h01;
    ipix.valid <= 1'b0;
    repeat (40) @(posedge clk);
    check({16'h0, cnt}, e, 32'h2);
    clr <= 1'b1;
  endtask : run
  task automatic finish_test();
    num_errors += int'(cyc >= 3000);
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, scaler_ofm_pkg::CTRL_RST);
    bus(1'b0, 4'h4, 32'h0001_0400);
    bus(1'b0, 4'h8, 32'h0000_0031);
    check({31'h0, swn}, 32'h1, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    bus(1'b1, 4'h0, 32'h0000_03C9);
    fld(2'b11, 1'b0, 1'b1, 4'b0110);
    fld(2'b11, 1'b1, 1'b1, 4'b0000);
    fld(2'b11, 1'b1, 1'b0, 4'b0000);
    bus(1'b1, 4'h0, 32'h0000_0106);
    fld(2'b10, 1'b1, 1'b1, 4'b1111);
    fld(2'b00, 1'b0, 1'b1, 4'b1010);
    bus(1'b1, 4'h4, 32'h0000_0400);
    bus(1'b0, 4'h4, 32'h0001_0400);
    run(32'h0001_0400, 32'd72);
    check({26'h0, ph}, 32'h0, 32'h0);
    run(32'h0002_0800, 32'd18);
    run(32'h0003_0300, 32'd32);
    finish_test();
  end
endmodule : scaler_ofm_tb
bind scaler_ofm scaler_ofm_properties scaler_ofm_properties_inst (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_field_start(i_field_start), .i_field_has_output(i_field_has_output),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_response(o_avs_response), .o_sav_eav_bit6(o_sav_eav_bit6), .o_sav_eav_bit7(o_sav_eav_bit7));
